// >>> hw/wics_pkg.sv
// Purpose: shared constants for the wake input and cyclic timer block
// Assumes: core clock of 200 MHz
// Notes: cycle counts derive from the printed times
package wics_pkg;

  typedef int unsigned wics_tab_t [8];

  localparam int unsigned WICS_CLK_MHZ = 200;
  localparam int unsigned WICS_CYC_PER_US = WICS_CLK_MHZ;
  localparam int unsigned WICS_CYC_PER_MS = 1000 * WICS_CYC_PER_US;

  localparam int unsigned WICS_FLT_SHORT_US = 16;
  localparam int unsigned WICS_FLT_LONG_US = 64;
  localparam int unsigned WICS_FLT_SHORT_CYC = WICS_FLT_SHORT_US * WICS_CYC_PER_US;
  localparam int unsigned WICS_FLT_LONG_CYC = WICS_FLT_LONG_US * WICS_CYC_PER_US;

  // on-time per code in microseconds, zero where the timer does not run
  localparam wics_tab_t WICS_ON_US = '{0, 100, 300, 1000, 10000, 20000, 0, 0};
  // period per code in milliseconds, code 7 reserved
  localparam wics_tab_t WICS_PER_MS = '{10, 20, 50, 100, 200, 1000, 2000, 0};

  // register addresses, 7 bits
  localparam logic [6:0] WICS_ADDR_PULL = 7'h08;
  localparam logic [6:0] WICS_ADDR_FILT = 7'h09;
  localparam logic [6:0] WICS_ADDR_TMR1 = 7'h0c;

  localparam logic [7:0] WICS_RST_PULL = 8'h00;
  localparam logic [7:0] WICS_RST_FILT = 8'h00;
  localparam logic [7:0] WICS_RST_TMR1 = 8'h00;

  // writable bits, the rest are reserved
  localparam logic [7:0] WICS_MASK_PULL = 8'h3f;
  localparam logic [7:0] WICS_MASK_FILT = 8'h3f;
  localparam logic [7:0] WICS_MASK_TMR1 = 8'h77;

  // timer field positions
  localparam int unsigned WICS_ON_LSB = 4;
  localparam int unsigned WICS_PER_LSB = 0;

  localparam logic [2:0] WICS_ON_STOP_LOW = 3'h0;
  localparam logic [2:0] WICS_ON_STOP_HIGH = 3'h6;
  localparam logic [2:0] WICS_ON_RESERVED = 3'h7;
  localparam logic [2:0] WICS_PER_RESERVED = 3'h7;
  localparam logic [2:0] WICS_HS_BY_TMR1 = 3'h2;

  localparam logic [1:0] WICS_FLT_STATIC_LONG = 2'h1;

  // frame layout: write flag, address, data
  localparam int unsigned WICS_FRAME_BITS = 16;
  localparam int unsigned WICS_HDR_BITS = 8;

  typedef enum logic [2:0] {
    WICS_SPI_IDLE = 3'b001,
    WICS_SPI_HDR = 3'b010,
    WICS_SPI_DATA = 3'b100
  } wics_spi_e;

  function automatic wics_tab_t wics_scale(wics_tab_t t, int unsigned m);
    wics_tab_t r;
    for (int i = 0; i < 8; i++) begin
      r[i] = t[i] * m;
    end
    return r;
  endfunction

endpackage

// >>> hw/wics_top.sv
// Purpose: wake pull/filter configuration and the first cyclic timer
// Assumes: spi pins synchronous to core_clk, sck half period >= 2 cycles
// Notes: frame is 16 bits msb first: write flag, 7-bit address, data
`timescale 1ns/1ps
`default_nettype none

module wics_top #(
  parameter int WK_N = 3,
  parameter int HS_N = 4,
  parameter int unsigned FLT_SHORT_CYC = wics_pkg::WICS_FLT_SHORT_CYC,
  parameter int unsigned FLT_LONG_CYC = wics_pkg::WICS_FLT_LONG_CYC,
  parameter wics_pkg::wics_tab_t ON_CYC = wics_pkg::wics_scale(wics_pkg::WICS_ON_US, wics_pkg::WICS_CYC_PER_US),
  parameter wics_pkg::wics_tab_t PER_CYC = wics_pkg::wics_scale(wics_pkg::WICS_PER_MS, wics_pkg::WICS_CYC_PER_MS)
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic spi_sck,
  input wire logic spi_csn,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic [WK_N-1:0] wake_pin,
  input wire logic [WK_N-1:0] wake_enable,
  input wire logic measurement_select,
  input wire logic timer_one_wake_enable,
  input wire logic timer_two_out,
  input wire logic restart_mode,
  input wire logic hs_clear_pulse,
  input wire logic [3*HS_N-1:0] hs_config,
  output logic [1:0] input_one_pull_select,
  output logic [1:0] input_two_pull_select,
  output logic [1:0] input_three_pull_select,
  output logic [WK_N-1:0] wake_level,
  output logic [WK_N-1:0] wake_event,
  output logic timer_one_out,
  output logic timer_one_wake,
  output logic [HS_N-1:0] high_side_output
);
  import wics_pkg::*;

  localparam int CNT_W = 32;
  localparam int FLT_W = 16;

  // spi slave
  wics_spi_e spi_st_q;
  wics_spi_e spi_st_d;
  logic sck_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] rx_q;
  logic [7:0] tx_q;
  logic sdo_q;
  logic sdo_oe_q;

  logic [7:0] wake_pull_config_q;
  logic [7:0] wake_filter_config_q;
  logic [7:0] cyclic_timer_one_config_q;

  wire sck_rise = spi_sck & ~sck_q & ~spi_csn;
  wire sck_fall = ~spi_sck & sck_q & ~spi_csn;
  wire hdr_done = (spi_st_q == WICS_SPI_HDR) && (bit_cnt_q == 5'(WICS_HDR_BITS));
  wire [6:0] rd_addr = rx_q[6:0];
  wire [6:0] wr_addr = rx_q[14:8];
  wire [7:0] wr_data = rx_q[7:0];
  wire frame_full = (bit_cnt_q == 5'(WICS_FRAME_BITS));
  wire wr_stb = (spi_st_q == WICS_SPI_DATA) & spi_csn & frame_full & rx_q[15];
  wire wr_pull = wr_stb & (wr_addr == WICS_ADDR_PULL);
  wire wr_filt = wr_stb & (wr_addr == WICS_ADDR_FILT);
  wire wr_tmr = wr_stb & (wr_addr == WICS_ADDR_TMR1);

  // unmapped addresses read as zero
  wire [7:0] rd_data = (rd_addr == WICS_ADDR_PULL) ? wake_pull_config_q :
                       (rd_addr == WICS_ADDR_FILT) ? wake_filter_config_q :
                       (rd_addr == WICS_ADDR_TMR1) ? cyclic_timer_one_config_q : 8'h00;

  always_comb begin
    spi_st_d = spi_st_q;
    case (spi_st_q)
      WICS_SPI_IDLE: begin
        if (!spi_csn) begin
          spi_st_d = WICS_SPI_HDR;
        end
      end
      WICS_SPI_HDR: begin
        if (spi_csn) begin
          spi_st_d = WICS_SPI_IDLE;
        end else if (hdr_done) begin
          spi_st_d = WICS_SPI_DATA;
        end
      end
      WICS_SPI_DATA: begin
        if (spi_csn) begin
          spi_st_d = WICS_SPI_IDLE;
        end
      end
      default: spi_st_d = WICS_SPI_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      spi_st_q <= WICS_SPI_IDLE;
      sck_q <= 1'b0;
      bit_cnt_q <= 5'h00;
      rx_q <= 16'h0000;
    end else begin
      spi_st_q <= spi_st_d;
      sck_q <= spi_sck;
      bit_cnt_q <= (spi_st_q == WICS_SPI_IDLE) ? 5'h00 :
                   (sck_rise && !frame_full) ? bit_cnt_q + 5'h01 : bit_cnt_q;
      rx_q <= sck_rise ? {rx_q[14:0], spi_sdi} : rx_q;
    end
  end

  // read data goes out on falling edges after the header
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tx_q <= 8'h00;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      tx_q <= hdr_done ? rd_data : (sck_fall ? {tx_q[6:0], 1'b0} : tx_q);
      sdo_q <= (sck_fall && spi_st_q == WICS_SPI_DATA) ? tx_q[7] : (spi_csn ? 1'b0 : sdo_q);
      sdo_oe_q <= ~spi_csn;
    end
  end

  assign spi_sdo = sdo_q;
  assign spi_sdo_oe = sdo_oe_q;

  // registers
  wire [2:0] on_code = cyclic_timer_one_config_q[WICS_ON_LSB +: 3];
  wire [2:0] per_code = cyclic_timer_one_config_q[WICS_PER_LSB +: 3];
  wire [WK_N-1:0] flt_cyclic;
  wire any_cyclic = |flt_cyclic;
  wire tmr_clear = restart_mode & hs_clear_pulse & any_cyclic;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wake_pull_config_q <= WICS_RST_PULL;
      wake_filter_config_q <= WICS_RST_FILT;
      cyclic_timer_one_config_q <= WICS_RST_TMR1;
    end else begin
      wake_pull_config_q <= wr_pull ? (wr_data & WICS_MASK_PULL) : wake_pull_config_q;
      wake_filter_config_q <= wr_filt ? (wr_data & WICS_MASK_FILT) : wake_filter_config_q;
      // hardware clear takes priority over a write in the same cycle
      cyclic_timer_one_config_q <= tmr_clear ? WICS_RST_TMR1 :
                                   (wr_tmr ? (wr_data & WICS_MASK_TMR1) : cyclic_timer_one_config_q);
    end
  end

  assign input_one_pull_select = wake_pull_config_q[1:0];
  assign input_two_pull_select = wake_pull_config_q[3:2];
  assign input_three_pull_select = wake_pull_config_q[5:4];

  // timer one
  logic [CNT_W-1:0] tmr_cnt_q;
  logic [CNT_W-1:0] tmr_cnt_d;
  logic tmr_out_q;
  logic tmr_wake_q;
  logic [HS_N-1:0] hs_q;
  logic tmr_end_q;
  logic t2_q;
  logic t2_end_q;

  wire [CNT_W-1:0] on_len = CNT_W'(ON_CYC[on_code]);
  wire [CNT_W-1:0] per_len = CNT_W'(PER_CYC[per_code]);
  // reserved codes leave the timer stopped
  wire running = (on_code != WICS_ON_STOP_LOW) && (on_code != WICS_ON_STOP_HIGH) &&
                 (on_code != WICS_ON_RESERVED) && (per_code != WICS_PER_RESERVED);
  wire per_last = (tmr_cnt_q >= per_len - CNT_W'(1));
  // any timer write restarts the period from its start
  assign tmr_cnt_d = (!running || wr_tmr || per_last) ? '0 : tmr_cnt_q + CNT_W'(1);
  wire tmr_out_d = running ? (tmr_cnt_d < on_len) : (on_code == WICS_ON_STOP_HIGH);
  wire per_start = running && (tmr_cnt_d == '0) && (wr_tmr || per_last || !tmr_out_q);
  wire tmr_wake_d = per_start & timer_one_wake_enable;
  wire tmr_end_d = running & tmr_out_q & ~tmr_out_d;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tmr_cnt_q <= '0;
      tmr_out_q <= 1'b0;
      tmr_wake_q <= 1'b0;
      tmr_end_q <= 1'b0;
      t2_q <= 1'b0;
      t2_end_q <= 1'b0;
    end else begin
      tmr_cnt_q <= tmr_cnt_d;
      tmr_out_q <= tmr_out_d;
      tmr_wake_q <= tmr_wake_d;
      tmr_end_q <= tmr_end_d;
      t2_q <= timer_two_out;
      t2_end_q <= t2_q & ~timer_two_out;
    end
  end

  genvar h;
  generate
    for (h = 0; h < HS_N; h++) begin : g_hs
      wire hs_d = (hs_config[3*h +: 3] == WICS_HS_BY_TMR1) & tmr_out_d;
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          hs_q[h] <= 1'b0;
        end else begin
          hs_q[h] <= hs_d;
        end
      end
    end
  endgenerate

  assign timer_one_out = tmr_out_q;
  assign timer_one_wake = tmr_wake_q;
  assign high_side_output = hs_q;

  // wake inputs
  logic [WK_N-1:0] flt_change;
  logic [WK_N-1:0] wake_evt_q;

  genvar w;
  generate
    for (w = 0; w < WK_N; w++) begin : g_wake
      wire [1:0] fsel = wake_filter_config_q[2*w +: 2];
      // code 1x senses cyclically, low bit picks the timer
      wire win = fsel[0] ? t2_q : tmr_out_q;
      wire win_end = fsel[0] ? t2_end_q : tmr_end_q;
      wire [FLT_W-1:0] thr = (fsel == WICS_FLT_STATIC_LONG) ? FLT_W'(FLT_LONG_CYC) :
                             FLT_W'(FLT_SHORT_CYC);
      wire masked = measurement_select && (w < 2);
      wire evt_d = flt_change[w] & wake_enable[w] & ~masked;
      assign flt_cyclic[w] = fsel[1];

      wics_wake_filter #(.CNT_W(FLT_W)) u_filter (
        .core_clk(core_clk),
        .rstn(rstn),
        .sample(wake_pin[w]),
        .cyclic(fsel[1]),
        .window(win),
        .window_end(win_end),
        .thresh(thr),
        .level_q(wake_level[w]),
        .change_q(flt_change[w])
      );

      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          wake_evt_q[w] <= 1'b0;
        end else begin
          wake_evt_q[w] <= evt_d;
        end
      end
    end
  endgenerate

  assign wake_event = wake_evt_q;

  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_reg_write_pull: assert property (wr_pull |=> wake_pull_config_q == ($past(wr_data) & WICS_MASK_PULL))
    else $error("pull register write not stored");
  // register writes land one edge after the commit
  a_reg_write_filt: assert property (wr_filt |=> wake_filter_config_q == ($past(wr_data) & WICS_MASK_FILT))
    else $error("filter register write not stored");
  a_reg_write_tmr: assert property (wr_tmr && !tmr_clear |=>
                                    cyclic_timer_one_config_q == ($past(wr_data) & WICS_MASK_TMR1))
    else $error("timer register write not stored");
  // a read frame or a cut frame never changes a register
  a_read_no_write: assert property (spi_st_q != WICS_SPI_IDLE && spi_csn && !(frame_full && rx_q[15]) |=>
                                    $stable(wake_pull_config_q) && $stable(wake_filter_config_q) &&
                                    ($stable(cyclic_timer_one_config_q) || $past(tmr_clear)))
    else $error("register changed without a full write frame");
  a_sdo_released: assert property (spi_csn |=> !spi_sdo_oe && !spi_sdo)
    else $error("data out driven while deselected");
  a_reserved_zero: assert property (wake_pull_config_q[7:6] == 2'b00 && wake_filter_config_q[7:6] == 2'b00 &&
                                    cyclic_timer_one_config_q[7] == 1'b0 && cyclic_timer_one_config_q[3] == 1'b0)
    else $error("reserved bit reads nonzero");
  a_reset_zero: assert property ($rose(rstn) |-> wake_filter_config_q == WICS_RST_FILT &&
                                 wake_pull_config_q == WICS_RST_PULL && cyclic_timer_one_config_q == WICS_RST_TMR1)
    else $error("registers not zero after reset");
  a_reset_outputs: assert property ($rose(rstn) |-> !timer_one_out && !timer_one_wake &&
                                    high_side_output == '0 && wake_event == '0 && wake_level == '0)
    else $error("outputs not low after reset");
  a_stop_low: assert property (on_code == WICS_ON_STOP_LOW && !wr_tmr && !tmr_clear |=> !tmr_out_q && hs_q == '0)
    else $error("stopped timer output not low");
  a_stop_high: assert property (on_code == WICS_ON_STOP_HIGH && !wr_tmr && !tmr_clear |=> tmr_out_q)
    else $error("stopped timer output not high");
  // stopped-high timer drives its switches high
  a_hs_stop_high: assert property (on_code == WICS_ON_STOP_HIGH && !wr_tmr && !tmr_clear &&
                                   hs_config[2:0] == WICS_HS_BY_TMR1 |=> hs_q[0])
    else $error("stopped timer switch not high");
  a_restart_clear: assert property (tmr_clear |=> cyclic_timer_one_config_q == WICS_RST_TMR1)
    else $error("timer fields not cleared on restart");
  a_meas_mask: assert property (measurement_select |=> wake_evt_q[1:0] == 2'b00)
    else $error("masked wake input raised an event");
  a_wake_gate: assert property (tmr_wake_q |-> $past(timer_one_wake_enable) && $past(running))
    else $error("timer wake without enable");
  a_wake_at_start: assert property (tmr_wake_q |-> tmr_out_q && tmr_cnt_q == '0)
    else $error("timer wake away from period start");
  a_event_enable: assert property (|wake_evt_q |-> |($past(flt_change) & $past(wake_enable)))
    else $error("wake event without enabled filter change");
  // each switch follows timer one or stays off
  for (genvar s = 0; s < HS_N; s++) begin : g_hs_chk
    a_hs_follow: assert property (hs_config[3*s +: 3] == WICS_HS_BY_TMR1 |=> hs_q[s] == tmr_out_q)
      else $error("switch does not follow timer");
    a_hs_other_off: assert property (hs_config[3*s +: 3] != WICS_HS_BY_TMR1 |=> !hs_q[s])
      else $error("switch on without timer code");
  end
  a_on_window: assert property (running && !wr_tmr && tmr_out_q && $past(running) |-> tmr_cnt_q < on_len)
    else $error("timer high beyond on-time");
  // count never runs past its period
  a_period_bound: assert property (running |-> tmr_cnt_q < per_len)
    else $error("timer count beyond period");
  // end strobe follows the last on-time cycle
  a_end_strobe: assert property (tmr_end_q |-> !tmr_out_q && $past(tmr_out_q))
    else $error("end strobe away from on-time end");
  a_auto_start: assert property (wr_tmr && (wr_data[6:4] == 3'h1) && !tmr_clear &&
                                 (wr_data[2:0] != WICS_PER_RESERVED) |=> ##1 tmr_out_q)
    else $error("timer did not start on write");
  c_timer_wake: cover property (tmr_wake_q);
  c_cyclic_event: cover property (any_cyclic && |wake_evt_q);
  c_restart_clear: cover property (tmr_clear);
endmodule
`default_nettype wire

// >>> hw/wics_wake_filter.sv
// Purpose: deglitch filter for one wake input, static or cyclic
// Assumes: thresh at least 1, pin synchronous to core_clk
// Notes: cyclic mode counts only inside the sense window
`timescale 1ns/1ps
`default_nettype none
module wics_wake_filter #(
  parameter int CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sample,
  input wire logic cyclic,
  input wire logic window,
  input wire logic window_end,
  input wire logic [CNT_W-1:0] thresh,
  output logic level_q,
  output logic change_q
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  wire diff = sample ^ level_q;
  wire count_en = diff & (~cyclic | window);
  wire hit = (cnt_q >= (thresh - CNT_W'(1)));
  // static: accept once the change has stood thresh cycles
  // cyclic: judge only at the end of the on-time
  wire accept = diff & (cyclic ? (window_end & hit) : hit);
  wire cnt_clr = ~diff | accept | (cyclic & window_end);

  assign cnt_d = cnt_clr ? '0 : ((count_en & ~&cnt_q) ? cnt_q + CNT_W'(1) : cnt_q);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_q <= '0;
      level_q <= 1'b0;
      change_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      level_q <= accept ? sample : level_q;
      change_q <= accept;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_static_persist: assert property (change_q && !$past(cyclic) |-> $past(cnt_q) >= $past(thresh) - 1)
    else $error("static change accepted before filter time");
  a_cyclic_at_end: assert property (change_q && $past(cyclic) |-> $past(window_end))
    else $error("cyclic change accepted outside end of on-time");
  a_level_toggles: assert property (change_q |-> level_q != $past(level_q))
    else $error("change pulse without level change");
  c_static_change: cover property (change_q && !$past(cyclic));
  c_cyclic_change: cover property (change_q && $past(cyclic));
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Purpose: self-checking bench for the wake and cyclic timer block
// Assumes: shortened filter and timer counts
// Notes: reads and wake events are checked from note queues
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb;
  import wics_pkg::*;
  localparam wics_tab_t ON_T = '{0, 3, 5, 7, 9, 11, 0, 0};
  localparam wics_tab_t PER_T = '{20, 30, 40, 50, 60, 70, 80, 0};
  logic core_clk = 1'b0, rstn = 1'b0, sck, csn, sdi, sdo, rd_done;
  logic [7:0] rd_data;
  logic [2:0] pin = 3'h0, wen = 3'h0, lvl, ev;
  logic meas = 1'b0, t1_wen = 1'b1, t2 = 1'b0, rmode = 1'b0, hclr = 1'b0, t1_out, t1_wake;
  logic [11:0] hs_cfg = {3'h0, 3'h2, 3'h2, 3'h2};
  logic [1:0] p0, p1, p2;
  logic [3:0] hs;
  logic [31:0] seed = 32'ha28414c2;
  logic [7:0] exp_q[$];
  logic [2:0] ev_q[$];
  int n_fail = 0, comparisons = 0;
  logic [7:0] rd_exp;
  logic [2:0] ev_exp;

  initial forever #2.5 core_clk = ~core_clk;

  wics_spi_master m (.core_clk(core_clk), .spi_sdo(sdo), .spi_sck(sck), .spi_csn(csn), .spi_sdi(sdi),
    .rd_done(rd_done), .rd_data(rd_data));

  wics_top #(.FLT_SHORT_CYC(4), .FLT_LONG_CYC(8), .ON_CYC(ON_T), .PER_CYC(PER_T)) DUT (
    .core_clk(core_clk), .rstn(rstn), .spi_sck(sck), .spi_csn(csn), .spi_sdi(sdi), .spi_sdo(sdo),
    .spi_sdo_oe(), .wake_pin(pin), .wake_enable(wen), .measurement_select(meas),
    .timer_one_wake_enable(t1_wen), .timer_two_out(t2), .restart_mode(rmode), .hs_clear_pulse(hclr),
    .hs_config(hs_cfg), .input_one_pull_select(p0), .input_two_pull_select(p1), .input_three_pull_select(p2),
    .wake_level(lvl), .wake_event(ev), .timer_one_out(t1_out), .timer_one_wake(t1_wake),
    .high_side_output(hs));

  always @(posedge core_clk) begin
    if (rd_done) begin
      rd_exp = exp_q.pop_front();
      `CHK(rd_data, rd_exp)
    end
    if (rstn && ev !== 3'h0) begin
      ev_exp = (ev_q.size() > 0) ? ev_q.pop_front() : 3'h0;
      `CHK(ev, ev_exp)
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    m.xfer({1'b1, a, d});
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    m.xfer({1'b0, a, 8'h00});
  endtask

  // measures one full period after the restart that a write causes
  task automatic tmr(input logic [2:0] on, input logic [2:0] per);
    int h, l, w, k;
    h = 0;
    l = 0;
    w = 0;
    k = 0;
    wr(WICS_ADDR_TMR1, {1'b0, on, 1'b0, per});
    while (t1_out !== 1'b0 && k < 300) begin cyc(1); k++; end
    while (t1_out !== 1'b1 && k < 300) begin cyc(1); k++; end
    while (t1_out === 1'b1 && h < 300) begin
      `CHK(hs, 4'h7)
      w += int'(t1_wake);
      cyc(1);
      h++;
    end
    while (t1_out === 1'b0 && l < 300) begin
      `CHK(hs, 4'h0)
      w += int'(t1_wake);
      cyc(1);
      l++;
    end
    `CHK(h, ON_T[on])
    `CHK(h + l, PER_T[per])
    `CHK(w, int'(t1_wen))
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    stop_test();
  end

  initial begin
    logic [6:0] ad [3];
    logic [7:0] wv [3], mk [3];
    logic [31:0] r;
    int thr, w;
    ad = '{WICS_ADDR_PULL, WICS_ADDR_FILT, WICS_ADDR_TMR1};
    wv = '{8'hff, 8'hff, 8'hd9};
    mk = '{WICS_MASK_PULL, WICS_MASK_FILT, WICS_MASK_TMR1};
    cyc(3);
    rstn = 1'b1;
    cyc(1);
    for (int i = 0; i < 3; i++) begin
      rd(ad[i], 8'h00);
      wr(ad[i], wv[i]);
      rd(ad[i], wv[i] & mk[i]);
    end
    wr(7'h0a, 8'h5a);
    rd(7'h0a, 8'h00);
    r = rnd();
    wr(WICS_ADDR_PULL, r[7:0]);
    cyc(2);
    `CHK({p2, p1, p0}, r[5:0])
    rd(WICS_ADDR_PULL, r[7:0] & 8'h3f);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      if (i == 6) t1_wen = 1'b0;
      tmr(3'((i % 5) + 1), 3'(i));
    end
    t1_wen = 1'b1;
    wr(WICS_ADDR_TMR1, 8'h00);
    for (int k = 0; k < 2; k++) begin
      cyc(3 + 90 * k);
      `CHK({t1_out, hs}, 5'h00)
    end
    wr(WICS_ADDR_TMR1, 8'h60);
    for (int k = 0; k < 2; k++) begin
      cyc(3 + 90 * k);
      `CHK({t1_out, hs}, 5'h17)
    end
    $display("test timer done");
    wr(WICS_ADDR_FILT, 8'h04);
    wen = 3'b011;
    for (int j = 0; j < 2; j++) begin
      thr = j ? 8 : 4;
      pin[j] = 1'b1;
      cyc(thr - 2);
      pin[j] = 1'b0;
      cyc(20);
      `CHK(lvl[j], 1'b0)
      ev_q.push_back(3'(1 << j));
      pin[j] = 1'b1;
      cyc(thr - 1);
      `CHK(lvl[j], 1'b0)
      cyc(6);
      `CHK(lvl[j], 1'b1)
    end
    pin[2] = 1'b1;
    meas = 1'b1;
    pin[0] = 1'b0;
    cyc(20);
    `CHK(lvl, 3'b110)
    $display("test static filter done");
    meas = 1'b0;
    wen = 3'b111;
    wr(WICS_ADDR_TMR1, 8'h00);
    wr(WICS_ADDR_FILT, 8'h2c);
    ev_q.push_back(3'b100);
    pin[2] = 1'b0;
    cyc(60);
    `CHK(lvl[2], 1'b1)
    wr(WICS_ADDR_TMR1, 8'h10);
    cyc(60);
    `CHK(lvl[2], 1'b0)
    ev_q.push_back(3'b010);
    pin[1] = 1'b0;
    w = 0;
    for (int k = 0; k < 100; k++) begin
      w += int'(t1_wake);
      cyc(1);
    end
    `CHK(w, 5)
    `CHK(lvl[1], 1'b1)
    t2 = 1'b1;
    cyc(10);
    t2 = 1'b0;
    cyc(6);
    `CHK(lvl[1], 1'b0)
    rmode = 1'b1;
    hclr = 1'b1;
    cyc(1);
    hclr = 1'b0;
    rmode = 1'b0;
    cyc(2);
    rd(WICS_ADDR_TMR1, 8'h00);
    `CHK(t1_out, 1'b0)
    `CHK(ev_q.size(), 0)
    $display("test cyclic sense done");
    stop_test();
  end
endmodule
`default_nettype wire

// >>> sim/wics_spi_master.sv
// Purpose: spi master model that sends 16-bit register frames
// Assumes: sck half period of 4 core cycles, sck idles low
// Notes: sdi shows the inverted last bit outside frames
`timescale 1ns/1ps
`default_nettype none
module wics_spi_master (
  input wire logic core_clk,
  input wire logic spi_sdo,
  output logic spi_sck,
  output logic spi_csn,
  output logic spi_sdi,
  output logic rd_done,
  output logic [7:0] rd_data
);
  initial begin
    spi_sck = 1'b0;
    spi_csn = 1'b1;
    spi_sdi = 1'b0;
    rd_done = 1'b0;
    rd_data = 8'h00;
  end

  // one frame, msb first; read byte captured late in the low phase of each of the last 8 bits
  task automatic xfer(input logic [15:0] f);
    logic [7:0] r;
    r = 8'h00;
    @(negedge core_clk);
    spi_csn = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = f[i];
      repeat (4) @(negedge core_clk);
      if (i < 8) r = {r[6:0], spi_sdo};
      spi_sck = 1'b1;
      repeat (4) @(negedge core_clk);
      spi_sck = 1'b0;
    end
    repeat (4) @(negedge core_clk);
    spi_csn = 1'b1;
    spi_sdi = ~spi_sdi;
    rd_data = r;
    rd_done = ~f[15];
    @(negedge core_clk);
    rd_done = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire
